//--- hdl/rio_frame_defines.svh
// Purpose: Constants of the 32-byte cyclic remote I/O frame
// Assumes: Printed byte numbers per converter variant, converted by base
// Notes: Multi-byte fields travel high byte first
`ifndef RIO_FRAME_DEFINES_SVH
`define RIO_FRAME_DEFINES_SVH

`define RIO_FRAME_BYTES  32
`define RIO_SLOTS        8
// Variant 1: printed byte numbers start at 1
`define RIO_V1_CODE      8'h50
`define RIO_V1_BASE      1
`define RIO_V1_CONN      5
`define RIO_V1_SLOT0     7
`define RIO_V1_RADDR     23
`define RIO_V1_RCMD      25
`define RIO_V1_RDATA     27
// Variant 2: printed byte numbers start at 0
`define RIO_V2_CODE      8'h20
`define RIO_V2_BASE      0
`define RIO_V2_WDT       1
`define RIO_V2_CONN      4
`define RIO_V2_SLOT0     6
`define RIO_V2_RADDR     22
`define RIO_V2_RCMD      24
`define RIO_V2_RDATA     26
// Command and response word fields, and command FIFO depth
`define RIO_COMMAND_EXECUTE_TRIGGER_BIT     14
`define RIO_DONE_BIT     14
`define RIO_STAT_BIT     15
`define RIO_CODE_W       14
`define RIO_FIFO_DEPTH   8

`endif

//--- hdl/rio_pkg.sv
// Purpose: Shared types of the remote I/O frame ends
// Assumes: Nothing beyond the defines header
// Notes: State codes written out in binary
package rio_pkg;
	// Device end sequencing
	typedef enum logic [1:0] {
		RIO_DV_RX   = 2'b00,
		RIO_DV_LOAD = 2'b01,
		RIO_DV_TX   = 2'b10
	} rio_dev_state_type;
	// Controller end sequencing
	typedef enum logic [1:0] {
		RIO_CT_IDLE = 2'b00,
		RIO_CT_LOAD = 2'b01,
		RIO_CT_TX   = 2'b10,
		RIO_CT_RX   = 2'b11
	} rio_ctl_state_type;
endpackage

//--- hdl/rio_link_if.sv
// Purpose: Byte streams between controller and driver
// Assumes: Single clock shared by both ends
// Notes: Last marks byte 31 of each frame
interface rio_link_if;
	logic       cmd_valid;   // Command byte offered
	logic       cmd_ready;   // Device takes it
	logic [7:0] cmd_data;    // Command byte
	logic       cmd_last;    // Final byte of frame
	logic       rsp_valid;   // Response byte offered
	logic       rsp_ready;   // Controller takes it
	logic [7:0] rsp_data;    // Response byte
	logic       rsp_last;    // Final byte of frame
	modport device (input cmd_valid, cmd_data, cmd_last, rsp_ready,
		output cmd_ready, rsp_valid, rsp_data, rsp_last);
	modport controller (output cmd_valid, cmd_data, cmd_last, rsp_ready,
		input cmd_ready, rsp_valid, rsp_data, rsp_last);
endinterface

//--- hdl/rio_device_end.sv
// Purpose: Driver end: parses command frames, builds response frames
// Assumes: Controller keeps to one frame in flight
// Notes: Command bytes pass an 8-word FIFO before parsing
`include "rio_frame_defines.svh"

module rio_fifo
	import rio_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = `RIO_FIFO_DEPTH
)(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
	logic [AW:0]      wr_q, wr_d;     // Write pointer with wrap bit
	logic [AW:0]      rd_q, rd_d;     // Read pointer with wrap bit

	// Pointer arithmetic needs a power of two
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_chk
		$error("rio_fifo depth must be a power of two");
	end

	// Full when pointers differ only in wrap bit
	assign in_ready  = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem_q[rd_q[AW-1:0]];

	// Next pointers
	always_comb
	begin
		wr_d = wr_q + (AW+1)'(in_valid && in_ready);
		rd_d = rd_q + (AW+1)'(out_valid && out_ready);
	end

	// Pointer registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// Storage has no reset; only written entries are read
	always_ff @(posedge clk)
	begin
		if (in_valid && in_ready)
			mem_q[wr_q[AW-1:0]] <= in_data;
	end
endmodule

module rio_device_end
	import rio_pkg::*;
#(
	parameter int VARIANT = 1
)(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// Link to the controller
	rio_link_if.device             link,
	// Remote I/O toward the drive logic
	output logic [7:0][15:0]       rio_in_words,
	input  wire logic [7:0][15:0]  rio_out_words,
	input  wire logic [15:0]       conn_status,
	output logic                   frame_strobe,
	// Remote register toward the drive logic
	output logic [15:0]            reg_addr,
	output logic [`RIO_CODE_W-1:0] cmd_code,
	output logic [31:0]            cmd_data,
	output logic                   exec_start,
	output logic                   monitor_active,
	input  wire logic              exec_ack,
	input  wire logic              exec_status,
	input  wire logic [31:0]       exec_rdata
);
	localparam logic [7:0] CODE = (VARIANT == 1) ? `RIO_V1_CODE : `RIO_V2_CODE;
	localparam int BASE = (VARIANT == 1) ? `RIO_V1_BASE : `RIO_V2_BASE;
	localparam int CONN = ((VARIANT == 1) ? `RIO_V1_CONN : `RIO_V2_CONN) - BASE;
	localparam int SLOT = ((VARIANT == 1) ? `RIO_V1_SLOT0 : `RIO_V2_SLOT0) - BASE;
	localparam int RADR = ((VARIANT == 1) ? `RIO_V1_RADDR : `RIO_V2_RADDR) - BASE;
	localparam int RCMD = ((VARIANT == 1) ? `RIO_V1_RCMD : `RIO_V2_RCMD) - BASE;
	localparam int RDAT = ((VARIANT == 1) ? `RIO_V1_RDATA : `RIO_V2_RDATA) - BASE;
	localparam int LAST = `RIO_FRAME_BYTES - 1;

	// Only the two known converter variants exist
	if (VARIANT != 1 && VARIANT != 2)
	begin : g_chk
		$error("rio_device_end VARIANT must be 1 or 2");
	end

	rio_dev_state_type st_q, st_d;           // Sequencer
	logic [4:0]        idx_q, idx_d;         // Byte position
	logic [7:0]        buf_q [32];           // Received frame
	logic [7:0]        buf_d [32];
	logic [7:0]        wdt_q, wdt_d;         // Watchdog byte to echo
	logic [7:0][15:0]  rin_q, rin_d;         // Slot inputs held
	logic [7:0][15:0]  rsn_q, rsn_d;         // Slot outputs snapshot
	logic [15:0]       cst_q, cst_d;         // Connection snapshot
	logic [15:0]       radr_q, radr_d;       // Register address
	logic [15:0]       rcmd_q, rcmd_d;       // Command word
	logic [31:0]       rdat_q, rdat_d;       // Command data
	logic              command_execute_trigger_q, command_execute_trigger_d;       // Trigger seen last frame
	logic              done_q, done_d;       // Completion bit
	logic              stat_q, stat_d;       // Result bit
	logic [31:0]       rres_q, rres_d;       // Response data
	logic              fstb_q, fstb_d;       // Frame accepted pulse
	logic              xst_q, xst_d;         // Execute pulse
	logic [7:0]        txb_q, txb_d;         // Outgoing byte
	logic              txv_q, txv_d;         // Outgoing valid
	logic              f_ov, f_or;           // FIFO drain handshake
	logic [8:0]        f_od;                 // FIFO word: last, byte
	logic [7:0]        tx_byte;              // Byte for idx_q
	logic [15:0]       tx_word;              // Word holding that byte
	logic              tx_hi;                // High half of word

	// Command bytes buffered; back-pressure reaches the controller
	rio_fifo #(.WIDTH(9), .DEPTH(`RIO_FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (link.cmd_valid),
		.in_ready  (link.cmd_ready),
		.in_data   ({link.cmd_last, link.cmd_data}),
		.out_valid (f_ov),
		.out_ready (f_or),
		.out_data  (f_od)
	);
	// Parser stalls while a response is going out
	assign f_or = (st_q == RIO_DV_RX);

	// Response byte selector, high byte first in each field
	always_comb
	begin
		tx_hi   = (idx_q[0] == SLOT[0]);
		tx_word = 16'h0000;
		tx_byte = 8'h00;
		if (int'(idx_q) >= SLOT && int'(idx_q) < SLOT + 2 * `RIO_SLOTS)
			tx_word = rsn_q[3'((int'(idx_q) - SLOT) >> 1)];
		else if (int'(idx_q) >> 1 == RADR >> 1)
			tx_word = radr_q;
		else if (int'(idx_q) >> 1 == RCMD >> 1)
			tx_word = {stat_q, done_q, rcmd_q[`RIO_CODE_W-1:0]};
		else if (int'(idx_q) >> 1 == RDAT >> 1)
			tx_word = rres_q[31:16];
		else if (int'(idx_q) >> 1 == (RDAT >> 1) + 1)
			tx_word = rres_q[15:0];
		else if (int'(idx_q) >> 1 == CONN >> 1)
			tx_word = cst_q;
		if (idx_q == 5'd0)
			tx_byte = CODE;
		else if (VARIANT == 2 && int'(idx_q) == `RIO_V2_WDT)
			tx_byte = wdt_q;
		else
			tx_byte = tx_hi ? tx_word[15:8] : tx_word[7:0];
	end

	// Frame sequencer and remote register handshake
	always_comb
	begin
		st_d   = st_q;
		idx_d  = idx_q;
		buf_d  = buf_q;
		wdt_d  = wdt_q;
		rin_d  = rin_q;
		rsn_d  = rsn_q;
		cst_d  = cst_q;
		radr_d = radr_q;
		rcmd_d = rcmd_q;
		rdat_d = rdat_q;
		command_execute_trigger_d = command_execute_trigger_q;
		done_d = done_q;
		stat_d = stat_q;
		rres_d = rres_q;
		fstb_d = 1'b0;
		xst_d  = 1'b0;
		txb_d  = txb_q;
		txv_d  = txv_q;
		// Completion clears once the trigger is seen low
		if (!command_execute_trigger_q)
			done_d = 1'b0;
		// Answers from drive logic; the set wins over the clear
		if (exec_ack && command_execute_trigger_q)
		begin
			done_d = 1'b1;
			stat_d = exec_status;
			rres_d = exec_rdata;
		end
		case (st_q)
			RIO_DV_RX:
			begin
				if (f_ov)
				begin
					buf_d[idx_q] = f_od[7:0];
					idx_d        = idx_q + 5'd1;
					// Short frame: drop it and resynchronise
					if (f_od[8] && int'(idx_q) != LAST)
						idx_d = 5'd0;
					else if (int'(idx_q) == LAST)
					begin
						idx_d = 5'd0;
						// Wrong or missing code: no answer at all
						if (f_od[8] && buf_q[0] == CODE)
						begin
							for (int s = 0; s < `RIO_SLOTS; s++)
								rin_d[s] = {buf_q[SLOT + 2 * s], buf_q[SLOT + 2 * s + 1]};
							radr_d = {buf_q[RADR], buf_q[RADR + 1]};
							rcmd_d = {buf_q[RCMD], buf_q[RCMD + 1]};
							rdat_d = {buf_q[RDAT], buf_q[RDAT + 1],
								buf_q[RDAT + 2], buf_q[RDAT + 3]};
							wdt_d  = buf_q[1];
							rsn_d  = rio_out_words;
							cst_d  = conn_status;
							command_execute_trigger_d = buf_q[RCMD][`RIO_COMMAND_EXECUTE_TRIGGER_BIT - 8];
							fstb_d = 1'b1;
							// Only a 0 to 1 step launches execution
							if (buf_q[RCMD][`RIO_COMMAND_EXECUTE_TRIGGER_BIT - 8] && !command_execute_trigger_q)
							begin
								xst_d  = 1'b1;
								done_d = 1'b0;
							end
							st_d = RIO_DV_LOAD;
						end
					end
				end
			end
			RIO_DV_LOAD:
			begin
				txb_d = tx_byte;
				txv_d = 1'b1;
				st_d  = RIO_DV_TX;
			end
			RIO_DV_TX:
			begin
				if (link.rsp_ready)
				begin
					txv_d = 1'b0;
					if (int'(idx_q) == LAST)
					begin
						idx_d = 5'd0;
						st_d  = RIO_DV_RX;
					end
					else
					begin
						idx_d = idx_q + 5'd1;
						st_d  = RIO_DV_LOAD;
					end
				end
			end
			default:
			begin
				st_d  = RIO_DV_RX;
				idx_d = 5'd0;
				txv_d = 1'b0;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q   <= RIO_DV_RX;
			idx_q  <= 5'd0;
			buf_q  <= '{default: 8'h00};
			wdt_q  <= 8'h00;
			rin_q  <= '0;
			rsn_q  <= '0;
			cst_q  <= 16'h0000;
			radr_q <= 16'h0000;
			rcmd_q <= 16'h0000;
			rdat_q <= 32'h0000_0000;
			command_execute_trigger_q <= 1'b0;
			done_q <= 1'b0;
			stat_q <= 1'b0;
			rres_q <= 32'h0000_0000;
			fstb_q <= 1'b0;
			xst_q  <= 1'b0;
			txb_q  <= 8'h00;
			txv_q  <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			idx_q  <= idx_d;
			buf_q  <= buf_d;
			wdt_q  <= wdt_d;
			rin_q  <= rin_d;
			rsn_q  <= rsn_d;
			cst_q  <= cst_d;
			radr_q <= radr_d;
			rcmd_q <= rcmd_d;
			rdat_q <= rdat_d;
			command_execute_trigger_q <= command_execute_trigger_d;
			done_q <= done_d;
			stat_q <= stat_d;
			rres_q <= rres_d;
			fstb_q <= fstb_d;
			xst_q  <= xst_d;
			txb_q  <= txb_d;
			txv_q  <= txv_d;
		end
	end

	// Outputs
	assign link.rsp_valid = txv_q;
	assign link.rsp_data  = txb_q;
	assign link.rsp_last  = txv_q && (int'(idx_q) == LAST);
	assign rio_in_words   = rin_q;
	assign frame_strobe   = fstb_q;
	assign reg_addr       = radr_q;
	assign cmd_code       = rcmd_q[`RIO_CODE_W-1:0];
	assign cmd_data       = rdat_q;
	assign exec_start     = xst_q;
	assign monitor_active = command_execute_trigger_q;
endmodule

//--- hdl/rio_ctrl_end.sv
// Purpose: Controller end: sends command frames, parses responses
// Assumes: One frame in flight; device answers every good frame
// Notes: Reserved and header bytes other than the echo are ignored
`include "rio_frame_defines.svh"

module rio_ctrl_end
	import rio_pkg::*;
#(
	parameter int VARIANT = 1
)(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// Link to the driver
	rio_link_if.controller         link,
	// Request from the user
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic [7:0][15:0]  req_rio_in,
	input  wire logic [15:0]       req_reg_addr,
	input  wire logic [`RIO_CODE_W-1:0] req_code,
	input  wire logic              req_command_execute_trigger,
	input  wire logic [31:0]       req_data,
	input  wire logic [7:0]        req_wdt,
	// Response to the user
	output logic                   rsp_strobe,
	output logic                   rsp_bad,
	output logic [7:0][15:0]       rsp_rio_out,
	output logic [15:0]            rsp_reg_addr,
	output logic [`RIO_CODE_W-1:0] rsp_code,
	output logic                   rsp_done,
	output logic                   rsp_status,
	output logic [31:0]            rsp_data,
	output logic [7:0]             rsp_wdt
);
	localparam logic [7:0] CODE = (VARIANT == 1) ? `RIO_V1_CODE : `RIO_V2_CODE;
	localparam int BASE = (VARIANT == 1) ? `RIO_V1_BASE : `RIO_V2_BASE;
	localparam int SLOT = ((VARIANT == 1) ? `RIO_V1_SLOT0 : `RIO_V2_SLOT0) - BASE;
	localparam int RADR = ((VARIANT == 1) ? `RIO_V1_RADDR : `RIO_V2_RADDR) - BASE;
	localparam int RCMD = ((VARIANT == 1) ? `RIO_V1_RCMD : `RIO_V2_RCMD) - BASE;
	localparam int RDAT = ((VARIANT == 1) ? `RIO_V1_RDATA : `RIO_V2_RDATA) - BASE;
	localparam int LAST = `RIO_FRAME_BYTES - 1;

	// Only the two known converter variants exist
	if (VARIANT != 1 && VARIANT != 2)
	begin : g_chk
		$error("rio_ctrl_end VARIANT must be 1 or 2");
	end

	rio_ctl_state_type st_q, st_d;          // Sequencer
	logic [4:0]        idx_q, idx_d;        // Byte position
	logic [7:0]        ob_q [32];           // Outgoing frame
	logic [7:0]        ob_d [32];
	logic [7:0]        ib_q [32];           // Incoming frame
	logic [7:0]        ib_d [32];
	logic [7:0]        txb_q, txb_d;        // Link byte
	logic              txv_q, txv_d;        // Link valid
	logic              stb_q, stb_d;        // Response pulse
	logic              bad_q, bad_d;        // Echo mismatch

	// Frame sequencer
	always_comb
	begin
		st_d  = st_q;
		idx_d = idx_q;
		ob_d  = ob_q;
		ib_d  = ib_q;
		txb_d = txb_q;
		txv_d = txv_q;
		stb_d = 1'b0;
		bad_d = bad_q;
		case (st_q)
			RIO_CT_IDLE:
			begin
				if (req_valid)
				begin
					// Reserved bytes stay zero
					ob_d    = '{default: 8'h00};
					ob_d[0] = CODE;
					if (VARIANT == 2)
						ob_d[`RIO_V2_WDT] = req_wdt;
					for (int s = 0; s < `RIO_SLOTS; s++)
					begin
						ob_d[SLOT + 2 * s]     = req_rio_in[s][15:8];
						ob_d[SLOT + 2 * s + 1] = req_rio_in[s][7:0];
					end
					ob_d[RADR]     = req_reg_addr[15:8];
					ob_d[RADR + 1] = req_reg_addr[7:0];
					ob_d[RCMD]     = {1'b0, req_command_execute_trigger, req_code[`RIO_CODE_W-1:8]};
					ob_d[RCMD + 1] = req_code[7:0];
					ob_d[RDAT]     = req_data[31:24];
					ob_d[RDAT + 1] = req_data[23:16];
					ob_d[RDAT + 2] = req_data[15:8];
					ob_d[RDAT + 3] = req_data[7:0];
					idx_d = 5'd0;
					st_d  = RIO_CT_LOAD;
				end
			end
			RIO_CT_LOAD:
			begin
				txb_d = ob_q[idx_q];
				txv_d = 1'b1;
				st_d  = RIO_CT_TX;
			end
			RIO_CT_TX:
			begin
				if (link.cmd_ready)
				begin
					txv_d = 1'b0;
					idx_d = idx_q + 5'd1;
					st_d  = (int'(idx_q) == LAST) ? RIO_CT_RX : RIO_CT_LOAD;
				end
			end
			RIO_CT_RX:
			begin
				if (link.rsp_valid)
				begin
					ib_d[idx_q] = link.rsp_data;
					idx_d = idx_q + 5'd1;
					if (int'(idx_q) == LAST)
					begin
						stb_d = 1'b1;
						bad_d = (ib_q[0] != CODE) || !link.rsp_last;
						st_d  = RIO_CT_IDLE;
					end
				end
			end
			default:
			begin
				st_d  = RIO_CT_IDLE;
				txv_d = 1'b0;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q  <= RIO_CT_IDLE;
			idx_q <= 5'd0;
			ob_q  <= '{default: 8'h00};
			ib_q  <= '{default: 8'h00};
			txb_q <= 8'h00;
			txv_q <= 1'b0;
			stb_q <= 1'b0;
			bad_q <= 1'b0;
		end
		else
		begin
			st_q  <= st_d;
			idx_q <= idx_d;
			ob_q  <= ob_d;
			ib_q  <= ib_d;
			txb_q <= txb_d;
			txv_q <= txv_d;
			stb_q <= stb_d;
			bad_q <= bad_d;
		end
	end

	// Response fields come straight from the captured frame
	for (genvar s = 0; s < `RIO_SLOTS; s++)
	begin : g_slot
		assign rsp_rio_out[s] = {ib_q[SLOT + 2 * s], ib_q[SLOT + 2 * s + 1]};
	end
	assign rsp_reg_addr   = {ib_q[RADR], ib_q[RADR + 1]};
	assign rsp_code       = {ib_q[RCMD][`RIO_CODE_W-9:0], ib_q[RCMD + 1]};
	assign rsp_done       = ib_q[RCMD][`RIO_DONE_BIT - 8];
	assign rsp_status     = ib_q[RCMD][`RIO_STAT_BIT - 8];
	assign rsp_data       = {ib_q[RDAT], ib_q[RDAT + 1], ib_q[RDAT + 2], ib_q[RDAT + 3]};
	assign rsp_wdt        = (VARIANT == 2) ? ib_q[`RIO_V2_WDT] : 8'h00;
	assign rsp_strobe     = stb_q;
	assign rsp_bad        = bad_q;
	assign req_ready      = (st_q == RIO_CT_IDLE);
	assign link.cmd_valid = txv_q;
	assign link.cmd_data  = txb_q;
	assign link.cmd_last  = txv_q && (int'(idx_q) == LAST);
	assign link.rsp_ready = (st_q == RIO_CT_RX);
endmodule

//--- tb/rio_frame_monitor.sv
// Purpose: Wire checks on the link between the two frame ends
// Assumes: Variant one on this link, one frame in flight
// Notes: Byte indices wrap at 32 so they realign every frame
`include "rio_frame_defines.svh"

module rio_frame_monitor
	import rio_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// Command stream
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic [7:0] cmd_data,
	input wire logic       cmd_last,
	// Response stream
	input wire logic       rsp_valid,
	input wire logic       rsp_ready,
	input wire logic [7:0] rsp_data,
	input wire logic       rsp_last
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [4:0] cmd_idx_q, cmd_idx_d; // Command byte index
	logic [4:0] rsp_idx_q, rsp_idx_d; // Response byte index
	logic       cmd_hs;               // Command byte taken
	logic       rsp_hs;               // Response byte taken

	assign cmd_hs = cmd_valid && cmd_ready;
	assign rsp_hs = rsp_valid && rsp_ready;

	// Advance on each taken byte
	always_comb
	begin
		cmd_idx_d = cmd_idx_q + 5'(cmd_hs);
		rsp_idx_d = rsp_idx_q + 5'(rsp_hs);
	end

	// Index registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmd_idx_q <= 5'h00;
			rsp_idx_q <= 5'h00;
		end
		else
		begin
			cmd_idx_q <= cmd_idx_d;
			rsp_idx_q <= rsp_idx_d;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_CMD_CODE: assert property (cmd_hs && cmd_idx_q == 5'h00 |-> cmd_data == `RIO_V1_CODE)
		else $error("command code byte wrong");
	AST_RSP_CODE: assert property (rsp_hs && rsp_idx_q == 5'h00 |-> rsp_data == `RIO_V1_CODE)
		else $error("response code echo wrong");
	AST_CMD_LAST: assert property (cmd_hs |-> cmd_last == (cmd_idx_q == 5'h1f))
		else $error("command last not on byte 31");
	AST_RSP_LAST: assert property (rsp_hs |-> rsp_last == (rsp_idx_q == 5'h1f))
		else $error("response last not on byte 31");
	AST_CMD_RSVD: assert property (cmd_hs && cmd_idx_q >= 5'h1e |-> cmd_data == 8'h00)
		else $error("command reserved byte not zero");
	AST_RSP_RSVD: assert property (rsp_hs && rsp_idx_q >= 5'h1e |-> rsp_data == 8'h00)
		else $error("response reserved byte not zero");
	AST_CMD_WORD: assert property (cmd_hs && cmd_idx_q == 5'h18 |-> !cmd_data[7])
		else $error("command word bit 15 set");
	AST_CMD_GAP: assert property (cmd_hs |=> !cmd_valid)
		else $error("command byte not followed by a gap");
	AST_RSP_TURN: assert property (cmd_hs && cmd_last |-> ##[1:20] rsp_valid && rsp_idx_q == 5'h00)
		else $error("no response after command frame");

	// Main scenarios reached
	cover property (cmd_hs && cmd_last);
	cover property (rsp_hs && rsp_last);
	cover property (rsp_hs && rsp_idx_q == 5'h18 && rsp_data[6]);
endmodule

//--- tb/remote_io_frame_field_map_test.sv
// Purpose: Frame exchange tests for both ends and a lone device end
// Assumes: 250 MHz clock, inputs driven 1 ns after the edge
// Notes: Second link is driven by hand to fill the FIFO and send a wrong-code frame
`include "rio_frame_defines.svh"

module remote_io_frame_field_map_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic                   clk, resetn;          // Clock, reset
	logic                   req_valid, req_ready; // User request
	logic                   req_command_execute_trigger;
	logic [7:0][15:0]       req_rio_in, rio_out_words, rsp_rio_out, rio_in_words;
	logic [15:0]            req_reg_addr, rsp_reg_addr, reg_addr, conn_status;
	logic [`RIO_CODE_W-1:0] req_code, rsp_code, cmd_code;
	logic [31:0]            req_data, rsp_data, cmd_data, exec_rdata;
	logic [7:0]             req_wdt;
	logic                   rsp_strobe, rsp_bad, rsp_done, rsp_status;
	logic                   exec_start, monitor_active, exec_ack, exec_status;
	logic                   frame_strobe;         // Frame accepted pulse
	int                     error_cnt, n_compared, n_start, n_frame;

	rio_link_if lk();  // Both design ends
	rio_link_if lk2(); // Bench facing a lone device end

	rio_ctrl_end #(.VARIANT(1)) i_rio_ctrl_end (.clk(clk), .resetn(resetn), .link(lk),
		.req_valid(req_valid), .req_ready(req_ready), .req_rio_in(req_rio_in),
		.req_reg_addr(req_reg_addr), .req_code(req_code), .req_command_execute_trigger(req_command_execute_trigger),
		.req_data(req_data), .req_wdt(req_wdt), .rsp_strobe(rsp_strobe), .rsp_bad(rsp_bad),
		.rsp_rio_out(rsp_rio_out), .rsp_reg_addr(rsp_reg_addr), .rsp_code(rsp_code),
		.rsp_done(rsp_done), .rsp_status(rsp_status), .rsp_data(rsp_data), .rsp_wdt());
	rio_device_end #(.VARIANT(1)) i_rio_device_end (.clk(clk), .resetn(resetn), .link(lk),
		.rio_in_words(rio_in_words), .rio_out_words(rio_out_words),
		.conn_status(conn_status), .frame_strobe(frame_strobe), .reg_addr(reg_addr),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .exec_start(exec_start),
		.monitor_active(monitor_active), .exec_ack(exec_ack),
		.exec_status(exec_status), .exec_rdata(exec_rdata));
	rio_device_end #(.VARIANT(2)) i_rio_device_end_v2 (.clk(clk), .resetn(resetn),
		.link(lk2), .rio_in_words(), .rio_out_words(rio_out_words),
		.conn_status(conn_status), .frame_strobe(), .reg_addr(), .cmd_code(),
		.cmd_data(), .exec_start(), .monitor_active(), .exec_ack(exec_ack),
		.exec_status(exec_status), .exec_rdata(exec_rdata));
	rio_frame_monitor i_rio_frame_monitor (.clk(clk), .resetn(resetn),
		.cmd_valid(lk.cmd_valid), .cmd_ready(lk.cmd_ready), .cmd_data(lk.cmd_data),
		.cmd_last(lk.cmd_last), .rsp_valid(lk.rsp_valid), .rsp_ready(lk.rsp_ready),
		.rsp_data(lk.rsp_data), .rsp_last(lk.rsp_last));

	// Free-running clock
	always #2 clk = ~clk;

	// Count execute and frame pulses of the first device
	always @(posedge clk)
	begin
		if (exec_start === 1'b1)
			n_start++;
		if (frame_strobe === 1'b1)
			n_frame++;
	end

	// Compare and report
	task chk(input logic [127:0] g, input logic [127:0] e);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	// Verdict, the only exit
	task results();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One user exchange; hold the request until the edge that takes it
	task xfer(input logic t, input logic [31:0] d);
		int n;
		req_command_execute_trigger = t;
		req_data = d;
		req_valid = 1'b1;
		while (req_ready !== 1'b1) @(posedge clk) #1;
		@(posedge clk) #1;
		req_valid = 1'b0;
		n = 0;
		while (rsp_strobe !== 1'b1 && n < 400)
		begin
			@(posedge clk) #1;
			n++;
		end
		// A response that never comes is a failure
		if (n >= 400)
			error_cnt++;
	endtask

	// One-cycle completion from the drive logic
	task ack(input logic s, input logic [31:0] d);
		exec_status = s;
		exec_rdata = d;
		exec_ack = 1'b1;
		@(posedge clk) #1;
		exec_ack = 1'b0;
	endtask

	// Send command bytes lo..hi-1 on the second link
	task frm(input logic [7:0] c, input logic [15:0] a, input int lo, input int hi);
		logic [15:0] w;
		for (int i = lo; i < hi; i++)
		begin
			w = (i < 22) ? 16'hc000 + 16'((i - 6) / 2) : (i < 24 ? a : 16'h4001);
			@(posedge clk) #1;
			lk2.cmd_valid = 1'b1;
			lk2.cmd_last = (i == 31);
			lk2.cmd_data = (i == 0) ? c : (i == 1) ? a[7:0] :
				(i >= 6 && i < 26) ? (i % 2 ? w[7:0] : w[15:8]) : 8'h00;
			while (lk2.cmd_ready !== 1'b1) @(posedge clk) #1;
			@(posedge clk) #1;
			lk2.cmd_valid = 1'b0;
		end
	endtask

	// Take and check one response frame on the second link
	task rcv(input logic [15:0] a);
		logic [15:0] w;
		lk2.rsp_ready = 1'b1;
		for (int i = 0; i < 32; i++)
		begin
			while (lk2.rsp_valid !== 1'b1) @(posedge clk) #1;
			w = (i < 22) ? rio_out_words[(i - 6) / 2] : a;
			chk(lk2.rsp_last, i == 31);
			if (i == 0)
				chk(lk2.rsp_data, `RIO_V2_CODE);
			else if (i == 1)
				chk(lk2.rsp_data, a[7:0]);
			else if (i == 4 || i == 5)
				chk(lk2.rsp_data, i == 4 ? conn_status[15:8] : conn_status[7:0]);
			else if (i >= 6 && i < 24)
				chk(lk2.rsp_data, i % 2 ? w[7:0] : w[15:8]);
			else if (i >= 24 && i < 30)
				chk(lk2.rsp_data, {7'h00, i == 25});
			else
				chk(lk2.rsp_data, 8'h00);
			@(posedge clk) #1;
		end
		lk2.rsp_ready = 1'b0;
	endtask

	// Hang guard, well above the expected run
	initial
	begin
		#40000;
		error_cnt++;
		results();
	end

	// Main sequence
	initial
	begin
		{clk, req_valid, req_command_execute_trigger, exec_ack, exec_status} = '0;
		{lk2.cmd_valid, lk2.cmd_last, lk2.rsp_ready} = '0;
		lk2.cmd_data = 8'h00;
		for (int s = 0; s < 8; s++)
		begin
			req_rio_in[s] = 16'h0a10 + 16'(s);
			rio_out_words[s] = 16'hb020 + 16'(s);
		end
		{req_reg_addr, req_code, req_data, req_wdt} = {16'h0003, 14'h2067, 32'h0, 8'h3c};
		{conn_status, exec_rdata} = {16'h00c5, 32'h0};
		resetn = 1'b0;
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		// Trigger rise: fields land and execution starts once
		xfer(1'b1, 32'h1234_5678);
		chk(rio_in_words, req_rio_in);
		chk(rsp_rio_out, rio_out_words);
		chk(reg_addr, 16'h0003);
		chk(rsp_reg_addr, 16'h0003);
		chk(cmd_code, 14'h2067);
		chk(rsp_code, 14'h2067);
		chk(cmd_data, 32'h1234_5678);
		chk(rsp_bad, 1'b0);
		chk(n_frame, 1);
		chk(n_start, 1);
		chk(monitor_active, 1'b1);
		// Abnormal completion, trigger held on
		ack(1'b1, 32'h0000_003c);
		xfer(1'b1, 32'h0);
		chk(n_start, 1);
		chk(rsp_done, 1'b1);
		chk(rsp_status, 1'b1);
		chk(rsp_data, 32'h0000_003c);
		// Monitor refresh, normal result
		ack(1'b0, 32'h0000_0041);
		xfer(1'b1, 32'h0);
		chk(rsp_status, 1'b0);
		chk(rsp_data, 32'h0000_0041);
		// Trigger off stops monitoring; a late ack is ignored
		xfer(1'b0, 32'h0);
		chk(monitor_active, 1'b0);
		ack(1'b1, 32'h0000_0099);
		xfer(1'b1, 32'h0);
		chk(n_start, 2);
		chk(n_frame, 5);
		chk(rsp_done, 1'b0);
		chk(rsp_data, 32'h0000_0041);
		// Wrong code for the second variant is dropped
		frm(`RIO_V1_CODE, 16'h0011, 0, 32);
		repeat (30)
		begin
			@(posedge clk) #1;
			chk(lk2.rsp_valid, 1'b0);
		end
		// Stalled response backs the FIFO up until it refuses
		frm(`RIO_V2_CODE, 16'h0077, 0, 32);
		repeat (10) @(posedge clk);
		frm(`RIO_V2_CODE, 16'h0155, 0, 8);
		@(posedge clk) #1;
		lk2.cmd_valid = 1'b1;
		lk2.cmd_data = 8'hc0;
		repeat (16)
		begin
			@(posedge clk) #1;
			chk(lk2.cmd_ready, 1'b0);
		end
		fork
			rcv(16'h0077);
			frm(`RIO_V2_CODE, 16'h0155, 8, 32);
		join
		rcv(16'h0155);
		results();
	end
endmodule
